// File: bench/gdc_channel_bench.sv
/*
 * Self-checking bench for the gated down-counter channel.
 * Assumes the channel and gdc_pulse_src; register bus driven here.
 */
`timescale 1ns/1ps

module gdc_channel_bench;
    import gdc_pkg::*;

    logic        mclk;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        pulse_in;
    logic        gate_input_pin;
    logic        digital_output;
    logic        irq_req;
    int          n_mismatch = 0;
    int          compares = 0;

    gdc_channel gdc_channel_i (
        .mclk           (mclk),
        .rst            (rst),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .pulse_in       (pulse_in),
        .gate_input_pin (gate_input_pin),
        .digital_output (digital_output),
        .irq_req        (irq_req)
    );

    gdc_pulse_src gdc_pulse_src_i (
        .pulse_in       (pulse_in),
        .gate_input_pin (gate_input_pin)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata & m, e, what);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic report_and_stop;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk(digital_output, 1'b0, "output after reset");
        chk(irq_req, 1'b0, "irq after reset");
        rc(GDC_OFS_CTRL, 32'hFFFF, 32'h0, "ctrl reset");
        rc(4'hF, 32'hFFFF_FFFF, 32'h0, "unmapped read");
        rc(GDC_OFS_STATUS, 32'h0007_4202, 32'h0, "status reset");
    endtask

    // Pin gate, count 3 to zero and on to -2, then capture
    task automatic t_count;
        wr(GDC_OFS_INIT, 32'h3);
        wr(GDC_OFS_CFG, 32'h3D);
        wr(GDC_OFS_CTRL, 32'h1);
        rc(GDC_OFS_ACTBIN, 32'hFFFF, 32'h3, "initial shown");
        gdc_pulse_src_i.set_gate(1'b1);
        cyc(10);
        gdc_pulse_src_i.pulses(3, 300);
        cyc(10);
        chk(digital_output, 1'b1, "output at zero");
        chk(irq_req, 1'b1, "zero irq");
        rc(GDC_OFS_IRQREQ, 32'hF, 32'h1, "zero request");
        cyc(3);
        chk(irq_req, 1'b0, "irq withdrawn");
        gdc_pulse_src_i.pulses(2, 700);
        cyc(10);
        rc(GDC_OFS_ACTBIN, 32'hFFFF, 32'h2, "below zero");
        rc(GDC_OFS_ACTBCD, 32'hFFFF, 32'h2, "bcd value");
        rc(GDC_OFS_STATUS, 32'h4103, 32'h4101, "sign zero out");
        gdc_pulse_src_i.set_gate(1'b0);
        cyc(10);
        chk(irq_req, 1'b1, "final irq");
        rc(GDC_OFS_FINAL, 32'hFFFF, 32'h2, "final value");
        rc(GDC_OFS_STATUS, 32'h70200, 32'h10200, "stored");
        rc(GDC_OFS_STATUS, 32'h200, 32'h0, "stored cleared");
        rc(GDC_OFS_IRQREQ, 32'hF, 32'h4, "final request");
    endtask

    // New initial count waits for the gate; start at zero; overwrite
    task automatic t_reload;
        wr(GDC_OFS_INIT, 32'h0);
        rc(GDC_OFS_ACTBIN, 32'hFFFF, 32'h2, "not yet applied");
        gdc_pulse_src_i.set_gate(1'b1);
        cyc(10);
        chk(digital_output, 1'b0, "output cleared");
        rc(GDC_OFS_STATUS, 32'h100, 32'h0, "zero cleared");
        rc(GDC_OFS_ACTBIN, 32'hFFFF, 32'h0, "applied");
        gdc_pulse_src_i.pulses(1, 300);
        cyc(10);
        rc(GDC_OFS_STATUS, 32'h4100, 32'h100, "zero start");
        rc(GDC_OFS_IRQREQ, 32'hE, 32'h0, "no other request");
        gdc_pulse_src_i.set_gate(1'b0);
        cyc(10);
        gdc_pulse_src_i.set_gate(1'b1);
        cyc(10);
        gdc_pulse_src_i.set_gate(1'b0);
        cyc(10);
        rc(GDC_OFS_IRQREQ, 32'hE, 32'hC, "overwrite irq");
        rc(GDC_OFS_STATUS, 32'h40000, 32'h40000, "overwrite");
    endtask

    // Forced levels; high is left through forced low
    task automatic t_force;
        wr(GDC_OFS_CTRL, 32'h3);
        cyc(3);
        chk(digital_output, 1'b1, "forced high");
        rc(GDC_OFS_STATUS, 32'h4000, 32'h4000, "state high");
        wr(GDC_OFS_CTRL, 32'h0);
        cyc(3);
        chk(digital_output, 1'b0, "forced low");
        rc(GDC_OFS_STATUS, 32'h4000, 32'h0, "state low");
    endtask

    // Soft gate from -9998, masked, into overrange
    task automatic t_overrange;
        wr(GDC_OFS_CTRL, 32'h8001);
        wr(GDC_OFS_INIT, 32'hD8F2);
        wr(GDC_OFS_CFG, 32'h0F);
        wr(GDC_OFS_CTRL, 32'h8011);
        cyc(10);
        gdc_pulse_src_i.pulses(1, 300);
        cyc(10);
        rc(GDC_OFS_ACTBCD, 32'hFFFF, 32'h9999, "bcd edge");
        rc(GDC_OFS_STATUS, 32'h3, 32'h1, "edge in range");
        gdc_pulse_src_i.pulses(1, 300);
        cyc(10);
        chk(irq_req, 1'b0, "masked irq");
        rc(GDC_OFS_IRQREQ, 32'hF, 32'h0, "masked lost");
        rc(GDC_OFS_STATUS, 32'h3, 32'h3, "overrange");
        rc(GDC_OFS_STATUS, 32'h2, 32'h0, "ovr cleared");
        wr(GDC_OFS_CTRL, 32'h8001);
        cyc(10);
        rc(GDC_OFS_STATUS, 32'h20000, 32'h20000, "final ovr");
        // Unmasked overrange: the request read alone clears the flag
        wr(GDC_OFS_CTRL, 32'h0001);
        wr(GDC_OFS_CTRL, 32'h0011);
        cyc(10);
        gdc_pulse_src_i.pulses(2, 300);
        cyc(10);
        chk(irq_req, 1'b1, "ovr irq");
        rc(GDC_OFS_IRQREQ, 32'hF, 32'h2, "ovr request");
        rc(GDC_OFS_STATUS, 32'h2, 32'h0, "ovr irq clear");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst       = 1'b1;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        cyc(2);
        t_reset();
        t_count();
        t_reload();
        t_force();
        t_overrange();
        report_and_stop();
    end

    // About fourteen times the expected run of some 420 cycles
    initial begin
        #300000;
        n_mismatch++;
        report_and_stop();
    end
endmodule

// File: bench/gdc_pulse_src.sv
/*
 * Process side model: count pulse source and gate pin of the channel.
 * Assumes the bench calls its tasks; both pins are asynchronous to mclk.
 */
`timescale 1ns/1ps

module gdc_pulse_src (
    output logic pulse_in,
    output logic gate_input_pin
);
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    initial begin
        pulse_in       = 1'b0;
        gate_input_pin = 1'b0;
    end

    // Odd delay keeps gate edges off the clock grid
    task automatic set_gate(input logic v);
        #137;
        gate_input_pin = v;
    endtask

    // Phases far above the synchroniser depth, so no edge is lost
    task automatic pulses(input int n, input int hi_ns);
        repeat (n) begin
            #(hi_ns);
            pulse_in = 1'b1;
            #(hi_ns);
            pulse_in = 1'b0;
        end
    endtask
endmodule

// File: hdl/gdc_bcd_conv.sv
/*
 * Combinational binary to four-digit BCD converter (double dabble).
 * Assumes the magnitude fits 0 to 9999; larger values wrap digits.
 */
`timescale 1ns/1ps

module gdc_bcd_conv
    import gdc_pkg::*;
(
    input  wire logic [13:0] bin,
    output logic [15:0]      bcd
);

    always_comb begin
        logic [29:0] sr;
        sr = {16'h0000, bin};
        for (int i = 0; i < 14; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (sr[14 + 4*d +: 4] > 4'h4) begin
                    sr[14 + 4*d +: 4] = sr[14 + 4*d +: 4] + 4'h3;
                end
            end
            sr = {sr[28:0], 1'b0};
        end
        bcd = sr[29:14];
    end

endmodule

// File: hdl/gdc_channel.sv
/*
 * Gated down-counter channel with final-count capture, zero and
 * overrange flags, interrupt request byte and one digital output.
 * Assumes a strobed register port on mclk; pulse and gate pins are
 * asynchronous and are synchronised here.
 */
//
// Overview of operation
// [RULE1] A counting cycle starts only on a rising edge of the gate.
// [RULE2] Gate comes from the soft control bit or the pin, by config.
// [RULE3] Gate active: each pulse rising edge decrements the count.
// [RULE4] Counting continues below zero, value grows negative.
// [RULE5] Beyond minus 9999 the counter is in overrange, flag set.
// [RULE6] Overrange flag may interrupt; cleared by status or IRQ read.
// [RULE7] In overrange only count; zero crossing gives no IRQ or output.
// [RULE8] New initial count applies at the next rising gate edge.
// [RULE9] After configuration the initial count shows as actual value.
// [RULE10] Actual value reported as BCD and binary magnitude plus sign.
// [RULE11] Reaching zero sets zero flag; may interrupt and set output.
// [RULE12] New gate edge clears zero flag; start at zero: no output.
// [RULE13] Falling gate edge captures final count, sets stored flag.
// [RULE14] Stored flag may interrupt; cleared by a status read.
// [RULE15] Final count reported as binary magnitude plus sign.
// [RULE16] Overrange at falling edge sets final overrange flag.
// [RULE17] Two captures without status read set overwrite flag.
// [RULE18] Force/set pair: 0/1 auto, 0/0 low, 1/1 high.
// [RULE19] Controller goes force-high to force-low before auto mode.
// [RULE20] Output state status bit mirrors the digital output.
// [RULE21] Reading the request bytes withdraws the interrupt.
// [RULE22] Enable bit 0 zero, bit 1 overrange, bit 2 final stored.
// [RULE23] Flags latch into request bytes on their rising edges.
// [RULE24] Mask bit set: no request and events are not recorded.
// [RULE25] Pulse and gate pins are synchronised and edge detected.
//
`timescale 1ns/1ps

module gdc_channel
    import gdc_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        pulse_in,
    input  wire logic        gate_input_pin,
    output logic             digital_output,
    output logic             irq_req
);

    // Magnitude and sign paths need at least 16 counter bits
    if (CNT_W < 16 || CNT_W > 24) begin : g_bad_cnt_w
        $error("gdc_channel: CNT_W must be 16 to 24");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]      ctrl;
        logic [7:0]       cfg;
        logic [15:0]      initial_count;
        logic signed [CNT_W-1:0] act;
        logic             counting;
        logic             gate_prev;
        logic             actual_overrange_flag;
        logic             ovr_state;
        logic             zero_reached_flag;
        logic             zero_silent;
        logic             final_stored_flag;
        logic [13:0]      final_mag;
        logic             final_sign;
        logic             final_overrange_flag;
        logic             final_overwrite_flag;
        logic             unread;
        logic [3:0]       irq_bytes;
        logic             ovr_from_irq;
        logic             out;
        logic             irq;
        logic [31:0]      rdata;
    } gdc_state_s;

    gdc_state_s st_ff;
    gdc_state_s nxt_st;

    logic        pulse_rise;
    logic        gate_pin_lvl;
    logic        irq_set_evt;
    logic [15:0] act_bcd;
    logic [13:0] act_mag;
    logic        actual_sign;

    gdc_edge_sync u_pulse_sync (
        .mclk  (mclk),
        .rst   (rst),
        .pin   (pulse_in),
        .level (),
        .rise  (pulse_rise),
        .fall  ()
    );

    gdc_edge_sync u_gate_sync (
        .mclk  (mclk),
        .rst   (rst),
        .pin   (gate_input_pin),
        .level (gate_pin_lvl),
        .rise  (),
        .fall  ()
    );

    logic signed [CNT_W-1:0] act_abs;
    assign actual_sign = st_ff.act[CNT_W-1];
    assign act_abs     = actual_sign ? -st_ff.act : st_ff.act;
    assign act_mag     = act_abs[13:0];

    gdc_bcd_conv u_bcd (
        .bin (act_mag),
        .bcd (act_bcd)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic gate;
        logic g_rise;
        logic g_fall;
        logic st_rd;
        logic irq_rd;
        logic masked;
        logic signed [CNT_W-1:0] dec;
        logic zero_evt;
        logic ovr_evt;
        logic fin_evt;
        logic owr_evt;
        logic auto_mode;
        gate      = 1'b0;
        g_rise    = 1'b0;
        g_fall    = 1'b0;
        dec       = '0;
        zero_evt  = 1'b0;
        ovr_evt   = 1'b0;
        fin_evt   = 1'b0;
        owr_evt   = 1'b0;
        nxt_st    = st_ff;
        st_rd     = reg_rd && reg_addr == GDC_OFS_STATUS;
        irq_rd    = reg_rd && reg_addr == GDC_OFS_IRQREQ;
        masked    = st_ff.ctrl[GDC_CTRL_IRQ_MASK];
        auto_mode = !st_ff.ctrl[GDC_CTRL_OUT_FORCE]
                    && st_ff.ctrl[GDC_CTRL_OUT_SET];

        // Gate source selection; see [RULE2]
        gate = st_ff.cfg[GDC_CFG_GATE_SRC] ? gate_pin_lvl
                                            : st_ff.ctrl[GDC_CTRL_GATE_SOFT];
        nxt_st.gate_prev = gate;
        g_rise = gate & ~st_ff.gate_prev;       // see [RULE25]
        g_fall = ~gate & st_ff.gate_prev;

        // Reads clear flags first, so events below win over clears
        if (st_rd) begin
            nxt_st.actual_overrange_flag = 1'b0;  // see [RULE6]
            nxt_st.final_stored_flag     = 1'b0;  // see [RULE14]
            nxt_st.final_overwrite_flag  = 1'b0;  // see [RULE17]
            nxt_st.unread                = 1'b0;
        end
        if (irq_rd) begin
            nxt_st.irq_bytes = 4'h0;              // see [RULE21]
            if (st_ff.ovr_from_irq) begin
                nxt_st.actual_overrange_flag = 1'b0;  // see [RULE6]
            end
            nxt_st.ovr_from_irq = 1'b0;
        end

        // Register writes
        if (reg_wr) begin
            if (reg_addr == GDC_OFS_CTRL) begin
                nxt_st.ctrl = reg_wdata[15:0];
            end else if (reg_addr == GDC_OFS_CFG) begin
                // Reconfiguring shows the initial count; see [RULE9]
                nxt_st.cfg      = reg_wdata[7:0];
                nxt_st.act      = CNT_W'(signed'(st_ff.initial_count));
                nxt_st.counting = 1'b0;
                nxt_st.ovr_state = 1'b0;
                nxt_st.irq_bytes = 4'h0;
            end else if (reg_addr == GDC_OFS_INIT) begin
                nxt_st.initial_count = reg_wdata[15:0];  // see [RULE8]
            end
        end

        // Counting
        if (g_rise) begin
            // New count loads the latest initial value; see [RULE1] [RULE8]
            nxt_st.act               = CNT_W'(signed'(st_ff.initial_count));
            nxt_st.counting          = 1'b1;
            nxt_st.ovr_state         = 1'b0;
            nxt_st.zero_reached_flag = 1'b0;      // see [RULE12]
            nxt_st.zero_silent       = (st_ff.initial_count == 16'h0000);
            if (auto_mode) begin
                nxt_st.out = 1'b0;                // see [RULE18]
            end
        end else if (st_ff.counting && gate && pulse_rise) begin
            dec = st_ff.act - CNT_W'(1);          // see [RULE3] [RULE4]
            nxt_st.act = dec;
            if (st_ff.zero_silent) begin
                // Start at zero: first pulse flags only; see [RULE12]
                nxt_st.zero_reached_flag = 1'b1;
                nxt_st.zero_silent       = 1'b0;
            end else if (dec == '0 && !st_ff.ovr_state) begin
                nxt_st.zero_reached_flag = 1'b1;  // see [RULE11] [RULE7]
                zero_evt = 1'b1;
            end
            if (!st_ff.ovr_state
                && dec < -CNT_W'(signed'(GDC_RANGE_MAX))) begin
                nxt_st.ovr_state             = 1'b1;   // see [RULE5]
                nxt_st.actual_overrange_flag = 1'b1;
                ovr_evt = 1'b1;
            end
        end

        if (g_fall) begin
            // Capture final value; see [RULE13] [RULE15] [RULE16]
            nxt_st.counting             = 1'b0;
            nxt_st.final_mag            = act_mag;
            nxt_st.final_sign           = actual_sign;
            nxt_st.final_overrange_flag = st_ff.ovr_state;
            nxt_st.final_stored_flag    = 1'b1;
            fin_evt = 1'b1;
            nxt_st.unread = 1'b1;
            if (st_ff.unread && !st_rd) begin
                nxt_st.final_overwrite_flag = 1'b1;  // see [RULE17]
                owr_evt = 1'b1;
            end
        end

        // Output control; see [RULE18] [RULE7]
        if (st_ff.ctrl[GDC_CTRL_OUT_FORCE]) begin
            nxt_st.out = st_ff.ctrl[GDC_CTRL_OUT_SET];
        end else if (!st_ff.ctrl[GDC_CTRL_OUT_SET]) begin
            nxt_st.out = 1'b0;
        end else if (zero_evt && st_ff.cfg[GDC_CFG_OUT_ZERO]) begin
            nxt_st.out = 1'b1;                    // see [RULE11]
        end

        // Request bytes latch rising flags unless masked
        if (!masked) begin                        // see [RULE24]
            if (zero_evt && st_ff.cfg[GDC_CFG_IEN_ZERO]) begin
                nxt_st.irq_bytes[GDC_IRQ_ZERO] = 1'b1;   // see [RULE22]
            end
            if (ovr_evt && st_ff.cfg[GDC_CFG_IEN_OVR]) begin
                nxt_st.irq_bytes[GDC_IRQ_OVR] = 1'b1;    // see [RULE23]
                nxt_st.ovr_from_irq = 1'b1;
            end
            if (fin_evt && st_ff.cfg[GDC_CFG_IEN_FINAL]) begin
                nxt_st.irq_bytes[GDC_IRQ_FINAL] = 1'b1;
            end
            if (owr_evt && st_ff.cfg[GDC_CFG_IEN_OWR]) begin
                nxt_st.irq_bytes[GDC_IRQ_OWR] = 1'b1;
            end
        end
        nxt_st.irq = (nxt_st.irq_bytes != 4'h0) && !masked;
        irq_set_evt = zero_evt || ovr_evt || fin_evt || owr_evt;

        // Read data, one cycle after the strobe
        nxt_st.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == GDC_OFS_CTRL) begin
                nxt_st.rdata = {16'h0000, st_ff.ctrl};
            end else if (reg_addr == GDC_OFS_CFG) begin
                nxt_st.rdata = {24'h000000, st_ff.cfg};
            end else if (reg_addr == GDC_OFS_INIT) begin
                nxt_st.rdata = {16'h0000, st_ff.initial_count};
            end else if (reg_addr == GDC_OFS_STATUS) begin
                nxt_st.rdata[GDC_ST_ACT_SIGN]  = actual_sign; // see [RULE10]
                nxt_st.rdata[GDC_ST_ACT_OVR]   = st_ff.actual_overrange_flag;
                nxt_st.rdata[GDC_ST_ZERO]      = st_ff.zero_reached_flag;
                nxt_st.rdata[GDC_ST_FINAL]     = st_ff.final_stored_flag;
                nxt_st.rdata[GDC_ST_OUT_STATE] = st_ff.out;   // see [RULE20]
                nxt_st.rdata[GDC_ST_FIN_SIGN]  = st_ff.final_sign;
                nxt_st.rdata[GDC_ST_FIN_OVR]   = st_ff.final_overrange_flag;
                nxt_st.rdata[GDC_ST_FIN_OWR]   = st_ff.final_overwrite_flag;
            end else if (reg_addr == GDC_OFS_ACTBCD) begin
                nxt_st.rdata = {16'h0000, act_bcd};           // see [RULE10]
            end else if (reg_addr == GDC_OFS_ACTBIN) begin
                nxt_st.rdata = {18'h00000, act_mag};
            end else if (reg_addr == GDC_OFS_FINAL) begin
                nxt_st.rdata = {18'h00000, st_ff.final_mag};  // see [RULE15]
            end else if (reg_addr == GDC_OFS_IRQREQ) begin
                nxt_st.rdata = {28'h0000000, st_ff.irq_bytes};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff               <= '0;
            st_ff.ctrl          <= GDC_RST_CTRL;
            st_ff.cfg           <= GDC_RST_CFG;
            st_ff.initial_count <= GDC_RST_INIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata      = st_ff.rdata;
    assign digital_output = st_ff.out;
    assign irq_req        = st_ff.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // An event in the read cycle may re-arm the request at once
    a_irq_read_clears: assert property ( // see [RULE21]
        @(posedge mclk) disable iff (rst)
        reg_rd && reg_addr == GDC_OFS_IRQREQ && !irq_set_evt |=> !irq_req)
        else $error("request not withdrawn after read");

    a_force_high: assert property ( // see [RULE18]
        @(posedge mclk) disable iff (rst)
        st_ff.ctrl[GDC_CTRL_OUT_FORCE] && st_ff.ctrl[GDC_CTRL_OUT_SET]
        |=> digital_output)
        else $error("forced high output not high");

    a_force_low: assert property ( // see [RULE18]
        @(posedge mclk) disable iff (rst)
        !st_ff.ctrl[GDC_CTRL_OUT_FORCE] && !st_ff.ctrl[GDC_CTRL_OUT_SET]
        |=> !digital_output)
        else $error("forced low output not low");

    a_mask_blocks: assert property ( // see [RULE24]
        @(posedge mclk) disable iff (rst)
        st_ff.ctrl[GDC_CTRL_IRQ_MASK] |=> !irq_req)
        else $error("masked channel requested");

    a_mask_no_record: assert property ( // see [RULE24]
        @(posedge mclk) disable iff (rst)
        st_ff.ctrl[GDC_CTRL_IRQ_MASK]
        |=> (st_ff.irq_bytes & ~$past(st_ff.irq_bytes)) == 4'h0)
        else $error("masked event recorded in request bits");

    a_fall_capture: assert property ( // see [RULE13]
        @(posedge mclk) disable iff (rst)
        !st_ff.gate_prev && $past(st_ff.gate_prev) && !$past(rst)
        |-> st_ff.final_stored_flag)
        else $error("final flag missing after fall");

    a_gate_rise_load: assert property ( // see [RULE12]
        @(posedge mclk) disable iff (rst)
        st_ff.gate_prev && !$past(st_ff.gate_prev) && !$past(rst)
        |-> st_ff.counting && !st_ff.zero_reached_flag)
        else $error("rising gate did not start a clean count");

endmodule

// File: hdl/gdc_edge_sync.sv
/*
 * Three-stage synchroniser with edge detection for one pin input.
 * Assumes the pin is asynchronous to mclk; edges count once the
 * second and third stages agree.
 */
`timescale 1ns/1ps

module gdc_edge_sync
    import gdc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic [2:0] sh;
        logic       lvl;
    } gdc_sync_s;

    gdc_sync_s st_ff;
    gdc_sync_s nxt_st;

    // Stage 0 feeds only stage 1; level changes when 1 and 2 agree
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.sh = {st_ff.sh[1:0], pin};
        if (st_ff.sh[1] == st_ff.sh[2]) begin
            nxt_st.lvl = st_ff.sh[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.lvl;
    assign rise  = (nxt_st.lvl & ~st_ff.lvl);
    assign fall  = (~nxt_st.lvl & st_ff.lvl);

endmodule

// File: hdl/gdc_pkg.sv
/*
 * Package for the gated down-counter channel: register map, field
 * positions, reset values and counting limits.
 * Assumes a simple strobed register port driven by a controller.
 */
package gdc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] GDC_OFS_CTRL   = 4'h0;
    localparam logic [3:0] GDC_OFS_CFG    = 4'h1;
    localparam logic [3:0] GDC_OFS_INIT   = 4'h2;
    localparam logic [3:0] GDC_OFS_STATUS = 4'h3;
    localparam logic [3:0] GDC_OFS_ACTBCD = 4'h4;
    localparam logic [3:0] GDC_OFS_ACTBIN = 4'h5;
    localparam logic [3:0] GDC_OFS_FINAL  = 4'h6;
    localparam logic [3:0] GDC_OFS_IRQREQ = 4'h7;

    // ------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------
    localparam int GDC_CTRL_GATE_SOFT  = 4;
    localparam int GDC_CTRL_OUT_SET    = 0;
    localparam int GDC_CTRL_OUT_FORCE  = 1;
    localparam int GDC_CTRL_IRQ_MASK   = 15;

    // ------------------------------------------------------------
    // Configuration word fields
    // ------------------------------------------------------------
    localparam int GDC_CFG_IEN_ZERO    = 0;
    localparam int GDC_CFG_IEN_OVR     = 1;
    localparam int GDC_CFG_IEN_FINAL   = 2;
    localparam int GDC_CFG_IEN_OWR     = 3;
    localparam int GDC_CFG_OUT_ZERO    = 4;
    localparam int GDC_CFG_GATE_SRC    = 5;

    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int GDC_ST_ACT_SIGN     = 0;
    localparam int GDC_ST_ACT_OVR      = 1;
    localparam int GDC_ST_ZERO         = 8;
    localparam int GDC_ST_FINAL        = 9;
    localparam int GDC_ST_OUT_STATE    = 14;
    localparam int GDC_ST_FIN_SIGN     = 16;
    localparam int GDC_ST_FIN_OVR      = 17;
    localparam int GDC_ST_FIN_OWR      = 18;

    // Interrupt request byte fields
    localparam int GDC_IRQ_ZERO        = 0;
    localparam int GDC_IRQ_OVR         = 1;
    localparam int GDC_IRQ_FINAL       = 2;
    localparam int GDC_IRQ_OWR         = 3;

    // ------------------------------------------------------------
    // Limits and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] GDC_RANGE_MAX  = 16'h270F;
    localparam logic [15:0] GDC_RST_INIT   = 16'h0000;
    localparam logic [15:0] GDC_RST_CTRL   = 16'h0000;
    localparam logic [7:0]  GDC_RST_CFG    = 8'h00;
    localparam int          GDC_SYNC_DEPTH = 3;

endpackage
